/* File: inc/adcsq_pkg.sv */
package adcsq_pkg;

   localparam int NSLOT = 16;
   localparam int RES_W = 12;

   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_CTL0  = 8'h00;
   localparam logic [7:0] IDX_CTL1  = 8'h02;
   localparam logic [7:0] IDX_GLBIE = 8'h06;
   localparam logic [7:0] IDX_IFG   = 8'h0a;
   localparam logic [7:0] IDX_IE    = 8'h0c;
   localparam logic [7:0] IDX_IV    = 8'h0e;
   localparam logic [7:0] IDX_MCTL0 = 8'h10;
   localparam logic [7:0] IDX_MEM0  = 8'h20;
   localparam logic [7:0] IDX_MEM15 = 8'h3e;

   // control word 0 fields
   localparam int CTL0_SHT1_LSB = 12;
   localparam int CTL0_SHT0_LSB = 8;
   localparam int CTL0_MSC      = 7;
   localparam int CTL0_OVIE     = 3;
   localparam int CTL0_TOVIE    = 2;
   localparam int CTL0_ENC      = 1;
   localparam int CTL0_SC       = 0;
   // bits of control word 0 writable while conversions are enabled
   localparam logic [15:0] CTL0_LIVE_MASK = 16'h000f;

   // control word 1 fields
   localparam int CTL1_START_LSB = 12;
   localparam int CTL1_SHS_LSB   = 10;
   localparam int CTL1_SHP       = 9;
   localparam int CTL1_ISSH      = 8;
   localparam int CTL1_SEQ_LSB   = 1;
   localparam int CTL1_BUSY      = 0;
   localparam logic [15:0] CTL1_LIVE_MASK = 16'h0006;
   localparam logic [15:0] CTL1_RW_MASK   = 16'hfffe;

   // slot control entry fields
   localparam int MCTL_EOS     = 7;
   localparam int MCTL_REF_LSB = 4;

   localparam logic [15:0] CTL_RST  = 16'h0000;
   localparam logic [3:0]  TEMP_CHANNEL = 4'ha;

   localparam logic [15:0] IV_NONE  = 16'h0000;
   localparam logic [15:0] IV_OVWR  = 16'h0002;
   localparam logic [15:0] IV_OVRUN = 16'h0004;
   localparam logic [15:0] IV_SLOT0 = 16'h0006;

   // sampling interval in converter clock cycles per sample-time code
   localparam int SHT_W = 11;
   localparam logic [15:0][SHT_W-1:0] SHT_CYCLES = {
      11'd1024, 11'd1024, 11'd1024, 11'd1024, 11'd768, 11'd512, 11'd384, 11'd256,
      11'd192,  11'd128,  11'd96,   11'd64,   11'd32,  11'd16,  11'd8,   11'd4};

   typedef enum logic [1:0] {
      MODE_SINGLE     = 2'b00,
      MODE_SEQ        = 2'b01,
      MODE_REP_SINGLE = 2'b10,
      MODE_REP_SEQ    = 2'b11
   } adcsq_mode_e;

   typedef struct packed {
      logic       sample;
      logic       start;
      logic [3:0] channel;
      logic [2:0] ref_sel;
      logic       int_ref_on;
   } adcsq_core_req_s;

   typedef struct packed {
      logic             done;
      logic [RES_W-1:0] result;
   } adcsq_core_rsp_s;

endpackage

/* File: design/adcsq_sample_timer.sv */
`timescale 1ns/1ps
module adcsq_sample_timer (
   input  wire logic       core_clk_in,
   input  wire logic       rst_b_in,
   input  wire logic       start_in,
   input  wire logic [3:0] sht_in,
   output logic            window_out,
   output logic            done_out
);

   typedef struct packed {
      logic [adcsq_pkg::SHT_W-1:0] cnt;
      logic                        run;
      logic                        done;
   } adcsq_tmr_s;

   adcsq_tmr_s r;
   adcsq_tmr_s n;

   always_comb begin
      n      = r;
      n.done = 1'b0;
      if (start_in) begin
         n.cnt = adcsq_pkg::SHT_CYCLES[sht_in];
         n.run = 1'b1;
      end else if (r.run) begin
         if (r.cnt == 11'd1) begin
            n.run  = 1'b0;
            n.done = 1'b1;
         end else begin
            n.cnt = r.cnt - 11'd1;
         end
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign window_out = r.run;
   assign done_out   = r.done;

endmodule

/* File: design/adcsq_sequencer.sv */
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
// Functional notes
// - sixteen result slots, each with channel, reference and end-of-sequence entry
// - sequence pointer wraps from slot fifteen to slot zero without end flag
// - start slot selects first entry; single-channel modes use only that entry
// - hidden pointer advances after each conversion; sequence ends after flagged entry
// - writing a result into a slot sets its result flag
// - mode 00 single once, 01 sequence once, 10 single repeat, 11 sequence repeat
// - non-repeat modes: software start re-triggers; other sources need enable toggled
// - repeat-single keeps converting one channel into the same slot
// - repeat-sequence restarts from start slot on next trigger after flagged entry
// - multi-convert with timer sampling: first edge starts, following conversions auto
// - multi-convert ignores further edges until sequence done or enable toggled
// - clearing enable in single-once mode aborts at once
// - clearing enable stops repeat-single after conversion, sequences after sequence
// - mode zero with enable cleared stops any mode immediately
// - with no end flag, clearing enable alone does not stop a sequence
// - channel 1010 selects temperature sensor and powers internal reference
// - eighteen sources; request needs flag, its enable and global enable
// - overwrite on unread slot rewrite; overrun on trigger while sampling or converting
// - dma trigger per conversion in single mode, per sequence in sequence mode
// - vector reports highest pending enabled source, zero when none
// - vector 2 overwrite, 4 overrun, 6 upward by two for slot flags
// - vector access clears overwrite or overrun if highest, never slot flags
// - slot flag clears on slot result access and by software write
// - sample window falling edge starts a conversion in the core
// - trigger rising edge starts sampling; polarity invertible
// - timer sampling holds window high for programmed interval
// - low sample time for slots 0-7, high for slots 8-15
module adcsq_sequencer #(
   parameter int ADDR_W = 12
) (
   input  wire logic                       core_clk_in,
   input  wire logic                       rst_b_in,
   input  wire logic                       psel_in,
   input  wire logic                       penable_in,
   input  wire logic                       pwrite_in,
   input  wire logic [ADDR_W-1:0]          paddr_in,
   input  wire logic [31:0]                pwdata_in,
   output logic                            pready_out,
   output logic [31:0]                     prdata_out,
   output logic                            pslverr_out,
   input  wire logic [2:0]                 trig_pins_in,
   input  wire adcsq_pkg::adcsq_core_rsp_s core_rsp_in,
   output adcsq_pkg::adcsq_core_req_s      core_req_out,
   output logic                            irq_out,
   output logic                            dma_trig_out
);

   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_SAMPLE = 2'b01,
      ST_CONV   = 2'b10
   } adcsq_st_e;

   typedef struct packed {
      logic [15:0]                         ctl0;
      logic [15:0]                         ctl1;
      logic [15:0]                         ifg;
      logic [15:0]                         ie;
      logic                                glbie;
      logic [15:0][7:0]                    mctl;
      logic [15:0][adcsq_pkg::RES_W-1:0]   mem;
      logic                                ovwr;
      logic                                ovrun;
      logic [3:0]                          ptr;
      adcsq_st_e                           st;
      logic                                seq_mid;
      logic                                armed;
      logic                                auto_run;
      logic                                trg_d;
      logic [2:0]                          sync1;
      logic [2:0]                          sync2;
      logic                                conv_start;
      logic                                dma;
      logic [31:0]                         prdata;
      logic                                pslverr;
   } adcsq_state_s;

   adcsq_state_s r;
   adcsq_state_s n;

   logic                  tmr_start;
   logic [3:0]            tmr_sht;
   logic                  tmr_window;
   logic                  tmr_done;

   function automatic logic [15:0] vector_of(input logic ovwr, input logic ovwr_en, input logic ovrun,
                                             input logic ovrun_en, input logic [15:0] flags);
      logic [15:0] v;
      v = adcsq_pkg::IV_NONE;
      for (int i = 15; i >= 0; i--) begin
         if (flags[i]) begin
            v = adcsq_pkg::IV_SLOT0 + 16'(2 * i);
         end
      end
      if (ovrun && ovrun_en) begin
         v = adcsq_pkg::IV_OVRUN;
      end
      if (ovwr && ovwr_en) begin
         v = adcsq_pkg::IV_OVWR;
      end
      return v;
   endfunction

   logic [15:0] iv_now;
   assign iv_now = vector_of(r.ovwr, r.ctl0[adcsq_pkg::CTL0_OVIE], r.ovrun,
                             r.ctl0[adcsq_pkg::CTL0_TOVIE], r.ifg & r.ie);

   always_comb begin
      logic [7:0]           idx;
      logic                 mapped;
      logic                 setup;
      logic                 access;
      logic                 is_mem;
      logic                 is_mctl;
      logic [3:0]           slot;
      logic                 enc;
      logic                 msc_auto;
      adcsq_pkg::adcsq_mode_e mode;
      logic [1:0]           shs;
      logic                 trg;
      logic                 rise;
      logic                 fall;
      logic                 is_seq;
      logic                 eos;
      logic                 go;
      logic [3:0]           start;
      logic [31:0]          rd;
      idx      = paddr_in[9:2];
      setup    = psel_in && !penable_in;
      access   = psel_in && penable_in;
      is_mem   = (idx >= adcsq_pkg::IDX_MEM0) && (idx <= adcsq_pkg::IDX_MEM15) && !idx[0];
      is_mctl  = idx[7:4] == adcsq_pkg::IDX_MCTL0[7:4];
      slot     = is_mem ? idx[4:1] : idx[3:0];
      mapped   = (paddr_in[1:0] == 2'b00) && !(|paddr_in[ADDR_W-1:10]) &&
                 (is_mem || is_mctl || idx == adcsq_pkg::IDX_CTL0 || idx == adcsq_pkg::IDX_CTL1 ||
                  idx == adcsq_pkg::IDX_GLBIE || idx == adcsq_pkg::IDX_IFG ||
                  idx == adcsq_pkg::IDX_IE || idx == adcsq_pkg::IDX_IV);
      enc      = r.ctl0[adcsq_pkg::CTL0_ENC];
      mode     = adcsq_pkg::adcsq_mode_e'(r.ctl1[adcsq_pkg::CTL1_SEQ_LSB +: 2]);
      shs      = r.ctl1[adcsq_pkg::CTL1_SHS_LSB +: 2];
      start    = r.ctl1[adcsq_pkg::CTL1_START_LSB +: 4];
      is_seq   = mode == adcsq_pkg::MODE_SEQ || mode == adcsq_pkg::MODE_REP_SEQ;
      eos      = r.mctl[r.ptr][adcsq_pkg::MCTL_EOS];
      msc_auto = r.ctl0[adcsq_pkg::CTL0_MSC] && r.ctl1[adcsq_pkg::CTL1_SHP] &&
                 mode != adcsq_pkg::MODE_SINGLE;
      go       = 1'b0;
      rd       = 32'h0000_0000;

      n            = r;
      n.conv_start = 1'b0;
      n.dma        = 1'b0;
      n.sync1      = trig_pins_in;
      n.sync2      = r.sync1;
      tmr_start    = 1'b0;

      // trigger source select and polarity
      trg   = ((shs == 2'b00) ? r.ctl0[adcsq_pkg::CTL0_SC] : r.sync2[shs - 2'd1]) ^
              r.ctl1[adcsq_pkg::CTL1_ISSH];
      n.trg_d = trg;
      rise  = trg && !r.trg_d;
      fall  = !trg && r.trg_d;

      // bus read data captured in the setup phase
      case (idx)
         adcsq_pkg::IDX_CTL0: rd = {16'h0000, r.ctl0};
         adcsq_pkg::IDX_CTL1: rd = {16'h0000, r.ctl1[15:1], (r.st != ST_IDLE) || r.seq_mid};
         adcsq_pkg::IDX_GLBIE: rd = {31'h0000_0000, r.glbie};
         adcsq_pkg::IDX_IFG:  rd = {16'h0000, r.ifg};
         adcsq_pkg::IDX_IE:   rd = {16'h0000, r.ie};
         adcsq_pkg::IDX_IV:   rd = {16'h0000, iv_now};
         default: begin
            if (is_mem) begin
               rd = {20'h0_0000, r.mem[slot]};
            end else if (is_mctl) begin
               rd = {24'h00_0000, r.mctl[slot]};
            end
         end
      endcase
      if (setup) begin
         n.prdata  = mapped ? rd : 32'h0000_0000;
         n.pslverr = !mapped;
      end

      // bus access phase effects
      if (access && mapped) begin
         if (pwrite_in) begin
            case (idx)
               adcsq_pkg::IDX_CTL0: begin
                  if (enc) begin
                     n.ctl0 = (r.ctl0 & ~adcsq_pkg::CTL0_LIVE_MASK) | (pwdata_in[15:0] & adcsq_pkg::CTL0_LIVE_MASK);
                  end else begin
                     n.ctl0 = pwdata_in[15:0];
                  end
               end
               adcsq_pkg::IDX_CTL1: begin
                  if (enc) begin
                     n.ctl1 = (r.ctl1 & ~adcsq_pkg::CTL1_LIVE_MASK) | (pwdata_in[15:0] & adcsq_pkg::CTL1_LIVE_MASK);
                  end else begin
                     n.ctl1 = pwdata_in[15:0] & adcsq_pkg::CTL1_RW_MASK;
                  end
               end
               adcsq_pkg::IDX_GLBIE: n.glbie = pwdata_in[0];
               adcsq_pkg::IDX_IFG: n.ifg = pwdata_in[15:0];
               adcsq_pkg::IDX_IE:  n.ie  = pwdata_in[15:0];
               default: begin
                  if (is_mem) begin
                     n.mem[slot] = pwdata_in[adcsq_pkg::RES_W-1:0];
                  end else if (is_mctl && !enc) begin
                     n.mctl[slot] = pwdata_in[7:0];
                  end
               end
            endcase
         end
         if (is_mem) begin
            n.ifg[slot] = 1'b0;
         end
         if (idx == adcsq_pkg::IDX_IV) begin
            if (iv_now == adcsq_pkg::IV_OVWR) begin
               n.ovwr = 1'b0;
            end
            if (iv_now == adcsq_pkg::IV_OVRUN) begin
               n.ovrun = 1'b0;
            end
         end
      end

      // disabling re-arms external trigger sources
      if (!enc) begin
         n.armed = 1'b1;
      end

      // trigger handling
      if (rise && !r.auto_run) begin
         if (r.st == ST_IDLE && (enc || r.seq_mid) && (r.armed || shs == 2'b00)) begin
            n.st       = ST_SAMPLE;
            n.auto_run = msc_auto;
            tmr_start  = r.ctl1[adcsq_pkg::CTL1_SHP];
            n.ctl0[adcsq_pkg::CTL0_SC] = 1'b0;
            if (!r.seq_mid) begin
               n.ptr = start;
            end
         end else if (r.st != ST_IDLE) begin
            n.ovrun = 1'b1;
         end
      end

      // end of sampling starts the conversion
      if (r.st == ST_SAMPLE && (r.ctl1[adcsq_pkg::CTL1_SHP] ? tmr_done : fall)) begin
         n.st         = ST_CONV;
         n.conv_start = 1'b1;
      end

      // conversion done
      if (r.st == ST_CONV && core_rsp_in.done) begin
         n.mem[r.ptr] = core_rsp_in.result;
         n.ifg[r.ptr] = 1'b1;
         if (r.ifg[r.ptr]) begin
            n.ovwr = 1'b1;
         end
         n.dma = !is_seq || eos;
         case (mode)
            adcsq_pkg::MODE_SINGLE: begin
               go = 1'b0;
            end
            adcsq_pkg::MODE_REP_SINGLE: begin
               go = enc;
            end
            adcsq_pkg::MODE_SEQ: begin
               go    = !eos;
               n.ptr = r.ptr + 4'h1;
            end
            adcsq_pkg::MODE_REP_SEQ: begin
               go    = eos ? enc : 1'b1;
               n.ptr = eos ? start : r.ptr + 4'h1;
            end
            default: begin
               go = 1'b0;
            end
         endcase
         n.seq_mid = is_seq && !eos;
         if (go && r.auto_run) begin
            n.st      = ST_SAMPLE;
            tmr_start = 1'b1;
         end else begin
            n.st       = ST_IDLE;
            n.auto_run = go && r.auto_run;
         end
         if (!go && (mode == adcsq_pkg::MODE_SINGLE || mode == adcsq_pkg::MODE_SEQ) && shs != 2'b00) begin
            n.armed = 1'b0;
         end
      end

      // immediate stop in single-once mode
      if (!enc && mode == adcsq_pkg::MODE_SINGLE) begin
         n.st       = ST_IDLE;
         n.seq_mid  = 1'b0;
         n.auto_run = 1'b0;
         tmr_start  = 1'b0;
      end
      tmr_sht = (n.ptr[3] ? r.ctl0[adcsq_pkg::CTL0_SHT1_LSB +: 4] :
                            r.ctl0[adcsq_pkg::CTL0_SHT0_LSB +: 4]);
   end

   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         r       <= '0;
         r.ctl0  <= adcsq_pkg::CTL_RST;
         r.ctl1  <= adcsq_pkg::CTL_RST;
         r.armed <= 1'b1;
         r.st    <= ST_IDLE;
      end else begin
         r <= n;
      end
   end

   adcsq_sample_timer u_timer (
      .core_clk_in (core_clk_in),
      .rst_b_in    (rst_b_in),
      .start_in    (tmr_start),
      .sht_in      (tmr_sht),
      .window_out  (tmr_window),
      .done_out    (tmr_done)
   );

   assign pready_out  = 1'b1;
   assign prdata_out  = r.prdata;
   assign pslverr_out = r.pslverr;
   assign irq_out     = r.glbie && (iv_now != adcsq_pkg::IV_NONE);
   assign dma_trig_out = r.dma;

   always_comb begin
      core_req_out.sample     = (r.st == ST_SAMPLE) &&
                                (r.ctl1[adcsq_pkg::CTL1_SHP] ? tmr_window : r.trg_d);
      core_req_out.start      = r.conv_start;
      core_req_out.channel    = r.mctl[r.ptr][3:0];
      core_req_out.ref_sel    = r.mctl[r.ptr][adcsq_pkg::MCTL_REF_LSB +: 3];
      core_req_out.int_ref_on = (r.st != ST_IDLE) && (r.mctl[r.ptr][3:0] == adcsq_pkg::TEMP_CHANNEL);
   end

endmodule

/* File: testbench/adcsq_sequencer_assertions.sv */
`timescale 1ns/1ps
module adcsq_sequencer_assertions #(
   parameter int ADDR_W = 12
) (
   input wire logic                       core_clk_in,
   input wire logic                       rst_b_in,
   input wire logic                       psel_in,
   input wire logic                       penable_in,
   input wire logic                       pwrite_in,
   input wire logic [ADDR_W-1:0]          paddr_in,
   input wire logic [31:0]                pwdata_in,
   input wire logic                       pready_out,
   input wire logic [31:0]                prdata_out,
   input wire logic                       pslverr_out,
   input wire logic [2:0]                 trig_pins_in,
   input wire adcsq_pkg::adcsq_core_rsp_s core_rsp_in,
   input wire adcsq_pkg::adcsq_core_req_s core_req_out,
   input wire logic                       irq_out,
   input wire logic                       dma_trig_out
);
   localparam logic [ADDR_W-1:0] GLB_A = ADDR_W'({adcsq_pkg::IDX_GLBIE, 2'b00});
   localparam logic [ADDR_W-1:0] IV_A  = ADDR_W'({adcsq_pkg::IDX_IV, 2'b00});
   logic glbie_seen_r;
   logic iv_rd;
   assign iv_rd = psel_in && penable_in && !pwrite_in && paddr_in == IV_A;
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!rst_b_in);
   // shadow of the global enable, taken from completed bus writes
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         glbie_seen_r <= 1'b0;
      end else if (psel_in && penable_in && pwrite_in && paddr_in == GLB_A) begin
         glbie_seen_r <= pwdata_in[0];
      end
   end
   a_start_one_cycle: assert property (core_req_out.start |=> !core_req_out.start [*8])
      else $error("start request not a single spaced pulse");
   a_start_after_window: assert property (core_req_out.start |->
      !core_req_out.sample && ($past(core_req_out.sample) || $past(core_req_out.sample, 2)))
      else $error("start request without a closing sample window");
   a_dma_after_done: assert property (dma_trig_out |-> $past(core_rsp_in.done))
      else $error("dma trigger without a finished conversion");
   a_dma_one_pulse: assert property ($rose(dma_trig_out) |=> !dma_trig_out)
      else $error("dma trigger longer than one cycle");
   a_temp_ref_on: assert property (core_req_out.start && core_req_out.channel == adcsq_pkg::TEMP_CHANNEL
      |-> ##[0:1] core_req_out.int_ref_on)
      else $error("internal reference off for temperature channel");
   a_ref_only_temp: assert property (core_req_out.int_ref_on |-> core_req_out.channel == adcsq_pkg::TEMP_CHANNEL)
      else $error("internal reference on for another channel");
   a_irq_needs_glbie: assert property (!glbie_seen_r |-> !irq_out)
      else $error("interrupt raised while global enable clear");
   a_iv_pending: assert property (iv_rd && $past(irq_out) |-> prdata_out != 32'h0)
      else $error("vector reads zero while a source is pending");
   a_iv_even_range: assert property (iv_rd |-> !prdata_out[0] && prdata_out <= 32'h24)
      else $error("vector value outside its encoding");
   c_dma: cover property (dma_trig_out);
   c_irq: cover property (irq_out);
   c_temp: cover property (core_req_out.start && core_req_out.channel == adcsq_pkg::TEMP_CHANNEL);
endmodule

bind adcsq_sequencer adcsq_sequencer_assertions #(.ADDR_W(ADDR_W)) u_chk (
   .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .psel_in(psel_in), .penable_in(penable_in),
   .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pready_out(pready_out),
   .prdata_out(prdata_out), .pslverr_out(pslverr_out), .trig_pins_in(trig_pins_in),
   .core_rsp_in(core_rsp_in), .core_req_out(core_req_out), .irq_out(irq_out), .dma_trig_out(dma_trig_out));

/* File: testbench/adcsq_core_model.sv */
`timescale 1ns/1ps
module adcsq_core_model #(
   parameter int CONV_CYC = 13
) (
   input  wire logic                       core_clk_in,
   input  wire logic                       rst_b_in,
   input  wire adcsq_pkg::adcsq_core_req_s core_req_in,
   input  wire logic                       slow_in,
   output adcsq_pkg::adcsq_core_rsp_s      core_rsp_out
);
   logic        busy_r;
   logic        done_r;
   logic [4:0]  cnt_r;
   logic [11:0] val_r;
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         busy_r <= 1'b0;
         done_r <= 1'b0;
         cnt_r  <= 5'h00;
         val_r  <= 12'h000;
      end else begin
         done_r <= 1'b0;
         if (core_req_in.start) begin
            busy_r <= 1'b1;
            cnt_r  <= 5'(CONV_CYC - 1) + (slow_in ? 5'h05 : 5'h00);
            val_r  <= {core_req_in.channel, core_req_in.ref_sel, 5'h15};
         end else if (busy_r && cnt_r == 5'h00) begin
            busy_r <= 1'b0;
            done_r <= 1'b1;
         end else if (busy_r) begin
            cnt_r <= cnt_r - 5'h01;
         end
      end
   end
   // result is only meaningful with done; otherwise it shows garbage
   assign core_rsp_out.done   = done_r;
   assign core_rsp_out.result = done_r ? val_r : ~val_r;
endmodule

/* File: testbench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   typedef struct packed {
      logic [11:0] a;
      logic [31:0] d;
      logic [31:0] x;
      logic        e;
   } adcsq_row_s;
   localparam logic [11:0] A_CTL0 = 12'h000, A_CTL1 = 12'h008, A_IFG = 12'h028, A_IE = 12'h030, A_IV = 12'h038;
   logic                       core_clk_in = 1'b0;
   logic                       rst_b_in    = 1'b0;
   logic                       psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0, e;
   logic [11:0]                paddr = 12'h000;
   logic [31:0]                pwdata = 32'h0, q;
   logic [2:0]                 trig = 3'h7;
   logic                       pready, pslverr, irq, dma;
   logic [31:0]                prdata;
   adcsq_pkg::adcsq_core_req_s req;
   adcsq_pkg::adcsq_core_rsp_s rsp;
   int                         miscompares = 0, n_tests = 0, cyc = 0, dmas = 0, starts = 0, d0, s0;
   adcsq_row_s                 rows [5];

   adcsq_sequencer dut (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pready_out(pready), .prdata_out(prdata),
      .pslverr_out(pslverr), .trig_pins_in(trig), .core_rsp_in(rsp), .core_req_out(req), .irq_out(irq),
      .dma_trig_out(dma));
   adcsq_core_model core (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .core_req_in(req), .slow_in(slow),
      .core_rsp_out(rsp));

   always #2 core_clk_in = ~core_clk_in;
   always @(posedge core_clk_in) begin
      cyc++;
      if (dma === 1'b1) dmas++;
      if (req.start === 1'b1) starts++;
      if (cyc == 60000) begin
         miscompares++;
         tally_and_finish();
      end
   end

   task tally_and_finish;
      if (miscompares == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk_in);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk_in);
      penable <= 1'b1;
      @(posedge core_clk_in);
      while (pready !== 1'b1) @(posedge core_clk_in);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   task rd(input logic [11:0] a, input logic [31:0] x);
      xfer(1'b0, a, 32'h0);
      chk(q, x);
   endtask
   task cfg(input logic [15:0] c1, input logic [15:0] c0);
      wr(A_CTL0, 32'h0);
      wr(A_CTL1, {16'h0, c1});
      wr(A_CTL0, {16'h0, c0});
   endtask
   task waitc(input int n);
      repeat (n) @(posedge core_clk_in);
   endtask
   task wait_dma(input int n);
      while (dmas < n) @(posedge core_clk_in);
   endtask
   function automatic logic [11:0] mem_a(input int n);
      return 12'h080 + 12'(8 * n);
   endfunction
   function automatic logic [31:0] res(input int n);
      return {20'h0, 4'(n + 7), 3'h2, 5'h15};
   endfunction

   initial begin
      rows[0] = '{12'h008, 32'hf306, 32'hf306, 1'b0};
      rows[1] = '{12'h054, 32'h00ba, 32'h00ba, 1'b0};
      rows[2] = '{A_IE, 32'ha5a5, 32'ha5a5, 1'b0};
      rows[3] = '{12'h018, 32'h0001, 32'h0001, 1'b0};
      rows[4] = '{12'h180, 32'h1234, 32'h0000, 1'b1};
      waitc(8);
      rst_b_in <= 1'b1;
      foreach (rows[i]) begin
         rd(rows[i].a, 32'h0);
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a, rows[i].x);
         chk({31'h0, e}, {31'h0, rows[i].e});
      end
      // slot n converts channel n+7, slot 0 alone closes a sequence
      for (int n = 0; n < 16; n++) wr(12'h040 + 12'(4 * n), {24'h0, n == 0, 3'h2, 4'(n + 7)});
      wr(A_IE, 32'h0);
      cfg(16'h3200, 16'h0003);
      wait_dma(1);
      rd(A_IFG, 32'h0008);
      rd(mem_a(3), res(3));
      rd(A_IFG, 32'h0);
      s0 = starts;
      cfg(16'he202, 16'h0083);
      wait_dma(2);
      chk(starts - s0, 3);
      rd(A_IFG, 32'hc001);
      wr(A_CTL0, 32'h0003);
      wait_dma(3);
      chk(starts - s0, 6);
      rd(A_IV, 32'h0);
      wr(A_CTL0, 32'h000a);
      wr(A_IE, 32'hffff);
      #1 chk(irq, 1'b1);
      rd(A_IV, 32'h2);
      rd(A_IV, 32'h6);
      rd(A_IV, 32'h6);
      wr(A_IFG, 32'h0);
      rd(A_IV, 32'h0);
      #1 chk(irq, 1'b0);
      cfg(16'h3200, 16'h0f07);
      waitc(20);
      wr(A_CTL0, 32'h0f07);
      rd(A_IV, 32'h4);
      rd(A_IV, 32'h0);
      s0 = starts;
      d0 = dmas;
      wr(A_CTL0, 32'h0);
      waitc(1100);
      chk(starts, s0);
      chk(dmas, d0);
      rd(A_IFG, 32'h0);
      slow <= 1'b1;
      s0 = starts;
      d0 = dmas;
      cfg(16'h6204, 16'h0083);
      wait_dma(d0 + 3);
      wr(A_CTL0, 32'h0080);
      waitc(100);
      chk(starts - s0, dmas - d0);
      d0 = dmas;
      waitc(100);
      chk(dmas, d0);
      rd(A_IFG, 32'h0040);
      rd(mem_a(6), res(6));
      slow <= 1'b0;
      // repeat sequence 15, 0 until enable drops, then finish the sequence
      s0 = starts;
      d0 = dmas;
      cfg(16'hf206, 16'h0083);
      wait_dma(d0 + 2);
      wr(A_CTL0, 32'h0080);
      waitc(100);
      chk(starts - s0, 2 * (dmas - d0));
      rd(A_IFG, 32'h8001);
      // inverted pin trigger: a falling pin is the rising edge
      cfg(16'h3700, 16'h0002);
      d0 = dmas;
      trig[0] <= 1'b0;
      wait_dma(d0 + 1);
      trig[0] <= 1'b1;
      waitc(50);
      trig[0] <= 1'b0;
      waitc(200);
      trig[0] <= 1'b1;
      waitc(100);
      chk(dmas, d0 + 1);
      wr(A_CTL0, 32'h0);
      wr(A_CTL0, 32'h0002);
      trig[0] <= 1'b0;
      wait_dma(d0 + 2);
      rd(mem_a(3), res(3));
      trig[0] <= 1'b1;
      waitc(50);
      trig[0] <= 1'b0;
      waitc(10);
      rst_b_in <= 1'b0;
      waitc(2);
      #1 chk({irq, dma, req, pslverr}, 13'h0);
      chk(prdata, 32'h0);
      trig[0] <= 1'b1;
      rst_b_in <= 1'b1;
      rd(A_CTL1, 32'h0);
      tally_and_finish();
   end
endmodule
